/* File: inc/framer_pkg.sv */
// Constants and types shared by the capture record framer.
package framer_pkg;
  // --------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SNAP     = 8'h04;
  localparam logic [7:0]  ADDR_RES      = 8'h08;
  localparam logic [7:0]  ADDR_STAT     = 8'h0c;
  localparam logic [7:0]  ADDR_COUNT    = 8'h10;
  localparam int          CTRL_TYPE_LSB = 0;
  localparam int          CTRL_EN_BIT   = 8;
  localparam int          STAT_BUSY_BIT = 16;
  localparam logic [2:0]  CTRL_TYPE_RST = 3'h1;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic [8:0]  SNAP_RST      = 9'h100;
  localparam logic [4:0]  RES_RST       = 5'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
  // --------------------------------------------------------------------
  // Record layout
  // --------------------------------------------------------------------
  localparam int          FLAG_VARY     = 2;
  localparam int          FLAG_TRUNC    = 3;
  localparam int          FLAG_RXERR    = 4;
  localparam int          FLAG_FAULT    = 5;
  localparam logic [15:0] HDR_BYTES     = 16'h0010;
  localparam logic [9:0]  ATM_CAP_BYTES = 10'h034;
  localparam logic [15:0] ATM_REC_BYTES = 16'h0044;
  localparam logic [8:0]  ETH_PAD_BYTES = 9'h002;
  localparam logic [9:0]  BUF_BYTES     = 10'h100;
  localparam int          BUF_WORDS     = 64;
  localparam logic [6:0]  HDR_WORDS     = 7'h04;
  localparam logic [15:0] LOSS_MAX      = 16'hffff;

  typedef enum logic [2:0] {
    legacy_record_code            = 3'h0,
    hdlc_record_code              = 3'h1,
    ethernet_record_code          = 3'h2,
    atm_cell_record_code          = 3'h3,
    reassembled_frame_record_code = 3'h4,
    multichannel_hdlc_record_code = 3'h5,
    multichannel_raw_record_code  = 3'h6,
    multichannel_cell_record_code = 3'h7
  } rec_type_t;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_collect = 2'b01,
    st_emit    = 2'b10
  } fsm_t;
endpackage

/* File: verilog/capture_record_framer.sv */
// Capture record framer with an AXI4-Lite register slave.
`timescale 1ns/10ps
// Overview of operation
// [R1] Timestamp words leave in little-endian order.
// [R2] Other header fields leave big-endian.
// [R3] Payload bytes copied in arrival order.
// [R4] Two stamp words, two header words, body.
// [R5] Type field uses the eight record codes.
// [R6] Flag bits 1-0 carry interface number.
// [R7] Flag bit 2 marks varying record lengths.
// [R8] Flag bit 3 marks truncated record.
// [R9] Flag bit 4 marks link receive error.
// [R10] Flag bit 5 internal fault; 7-6 reserved.
// [R11] Record length is total bytes transferred.
// [R12] Sixteen-bit loss count, saturating at ffff.
// [R13] Wire length is the received frame length.
// [R14] Consumer ignores the unused skip-count byte.
// [R15] Type 1: HDLC header, then packet data.
// [R16] Type 3: cell header, then 48 bytes.
// [R17] Ethernet frame follows pad, IP aligned.
// [R18] Each record stamped with arrival time.
// [R19] Stamp is 64-bit seconds since 1970.
// [R20] Upper half seconds, lower half fraction.
// [R21] Unresolved low fraction bits read zero.
// [R22] Loss counter clears after being reported.
module capture_record_framer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] ts_sec,
  input  wire logic [31:0] ts_frac,
  input  wire logic        in_valid,
  input  wire logic        in_first,
  input  wire logic        in_last,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_err,
  input  wire logic [1:0]  in_iface,
  output logic             in_ready,
  input  wire logic        fault,
  input  wire logic        drop,
  output logic             out_valid,
  output logic [31:0]      out_data,
  output logic             out_last,
  input  wire logic        out_ready
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    framer_pkg::fsm_t               st;
    logic                           awready;
    logic                           wready;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic [7:0]                     waddr;
    logic [31:0]                    wdat;
    logic [3:0]                     wstr;
    logic                           arready;
    logic                           rvalid;
    logic [1:0]                     rresp;
    logic [31:0]                    rdata;
    framer_pkg::rec_type_t          rtype;
    logic                           en;
    logic [8:0]                     snap;
    logic [4:0]                     res;
    logic [31:0]                    nrec;
    logic [15:0]                    lctr;
    logic [31:0]                    tsf;
    logic [31:0]                    tss;
    logic [1:0]                     iface;
    logic                           trunc;
    logic                           rxerr;
    logic                           flt;
    logic [9:0]                     pos;
    logic [15:0]                    wlen;
    logic                           in_ready;
    logic                           out_valid;
    logic                           out_last;
    logic [31:0]                    out_data;
    logic [6:0]                     widx;
    logic [6:0]                     nwords;
    logic [framer_pkg::BUF_WORDS-1:0][31:0] mem;
  } state_t;

  state_t      s;
  state_t      n;
  logic [15:0] rlen;
  logic [9:0]  lim;
  logic [7:0]  flags;
  logic        start;
  logic        ld3;
  logic [31:0] ctrl_m;
  logic [31:0] snap_m;
  logic [31:0] res_m;

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] be16(input logic [15:0] x);
    return {x[7:0], x[15:8]};
  endfunction

  // --------------------------------------------------------------------
  // Record fields
  // --------------------------------------------------------------------
  always_comb begin
    rlen = framer_pkg::HDR_BYTES + {6'h00, s.pos + 10'h003} & 16'hfffc; // [R11]
    if (s.rtype == framer_pkg::atm_cell_record_code) begin
      lim = framer_pkg::ATM_CAP_BYTES; // [R16]
    end else if (s.rtype == framer_pkg::ethernet_record_code) begin
      lim = {1'b0, s.snap} + {1'b0, framer_pkg::ETH_PAD_BYTES};
    end else begin
      lim = {1'b0, s.snap};
    end
    if (lim > framer_pkg::BUF_BYTES) begin
      lim = framer_pkg::BUF_BYTES; // [R8]
    end
    flags = 8'h00; // [R10]
    flags[1:0] = s.iface; // [R6]
    flags[framer_pkg::FLAG_VARY] =
      (s.rtype != framer_pkg::atm_cell_record_code); // [R7]
    flags[framer_pkg::FLAG_TRUNC] = s.trunc; // [R8]
    flags[framer_pkg::FLAG_RXERR] = s.rxerr; // [R9]
    flags[framer_pkg::FLAG_FAULT] = s.flt; // [R10]
    start = s.st == framer_pkg::st_idle && s.in_ready && in_valid && in_first;
    ld3 = s.st == framer_pkg::st_emit && (!s.out_valid || out_ready)
      && s.widx == 7'h03;
    ctrl_m = wmerge({23'h0, s.en, 5'h0, s.rtype}, s.wdat, s.wstr);
    snap_m = wmerge({23'h0, s.snap}, s.wdat, s.wstr);
    res_m = wmerge({27'h0, s.res}, s.wdat, s.wstr);
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    n = s;
    // Register bus: address and data are taken in either order.
    if (awvalid && s.awready) begin
      n.awready = 1'b0;
      n.waddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.wready = 1'b0;
      n.wdat = wdata;
      n.wstr = wstrb;
    end
    if (!s.awready && !s.wready && !s.bvalid) begin
      n.bvalid = 1'b1;
      n.bresp = framer_pkg::RESP_OKAY;
      case (s.waddr)
        framer_pkg::ADDR_CTRL: begin
          n.rtype = framer_pkg::rec_type_t'(
            ctrl_m[framer_pkg::CTRL_TYPE_LSB +: 3]); // [R5]
          n.en = ctrl_m[framer_pkg::CTRL_EN_BIT];
        end
        framer_pkg::ADDR_SNAP:
          n.snap = snap_m[8:0];
        framer_pkg::ADDR_RES:
          n.res = res_m[4:0];
        framer_pkg::ADDR_STAT, framer_pkg::ADDR_COUNT: begin
        end
        default: n.bresp = framer_pkg::RESP_DECERR;
      endcase
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = framer_pkg::RESP_OKAY;
      case (araddr)
        framer_pkg::ADDR_CTRL:  n.rdata = {23'h0, s.en, 5'h0, s.rtype};
        framer_pkg::ADDR_SNAP:  n.rdata = {23'h0, s.snap};
        framer_pkg::ADDR_RES:   n.rdata = {27'h0, s.res};
        framer_pkg::ADDR_STAT:
          n.rdata = {15'h0, s.st != framer_pkg::st_idle, s.lctr};
        framer_pkg::ADDR_COUNT: n.rdata = s.nrec;
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = framer_pkg::RESP_DECERR;
        end
      endcase
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    // Loss counter: a drop in the clearing cycle still counts.
    if (ld3) begin
      n.lctr = 16'h0000; // [R22]
    end
    if (drop && n.lctr != framer_pkg::LOSS_MAX) begin
      n.lctr = n.lctr + 16'h0001; // [R12]
    end
    case (s.st)
      framer_pkg::st_idle: begin
        if (start) begin
          n.st = framer_pkg::st_collect;
          n.tss = ts_sec; // [R18] [R19] [R20]
          n.tsf = ts_frac & (32'hffff_ffff << s.res); // [R1] [R21]
          n.iface = in_iface;
          n.trunc = 1'b0;
          n.rxerr = 1'b0;
          n.flt = 1'b0;
          n.wlen = 16'h0000;
          n.mem = '0;
          n.pos = 10'h000;
          if (s.rtype == framer_pkg::ethernet_record_code) begin
            n.pos = {1'b0, framer_pkg::ETH_PAD_BYTES}; // [R17]
          end
        end
      end
      framer_pkg::st_collect: begin
      end
      framer_pkg::st_emit: begin
        if (!s.out_valid || out_ready) begin
          if (s.widx < s.nwords) begin
            n.out_valid = 1'b1;
            n.out_last = s.widx == s.nwords - 7'h01;
            n.widx = s.widx + 7'h01;
            case (s.widx)
              7'h00: n.out_data = s.tsf; // [R1] [R20]
              7'h01: n.out_data = s.tss; // [R1] [R20]
              7'h02: n.out_data = {be16(rlen), flags, 5'h00, s.rtype}; // [R2] [R4] [R5]
              7'h03: n.out_data = {be16(s.wlen), be16(s.lctr)}; // [R2] [R4] [R13]
              default: n.out_data =
                s.mem[6'(s.widx - framer_pkg::HDR_WORDS)]; // [R3] [R15]
            endcase
          end else begin
            n.out_valid = 1'b0;
            n.out_last = 1'b0;
            n.st = framer_pkg::st_idle;
            n.nrec = s.nrec + 32'h0000_0001;
          end
        end
      end
      default: n.st = framer_pkg::st_idle;
    endcase
    // Byte capture: first byte lands together with the start.
    if (start || (s.st == framer_pkg::st_collect && in_valid)) begin
      n.wlen = n.wlen + 16'h0001; // [R13]
      n.rxerr = n.rxerr | in_err; // [R9]
      n.flt = n.flt | fault; // [R10]
      if (n.pos < lim) begin
        n.mem[n.pos[7:2]][{n.pos[1:0], 3'b000} +: 8] = in_data; // [R3]
        n.pos = n.pos + 10'h001;
      end else begin
        n.trunc = 1'b1; // [R8]
      end
      if (in_last) begin
        n.st = framer_pkg::st_emit;
        n.widx = 7'h00;
        if (s.rtype == framer_pkg::atm_cell_record_code) begin
          n.pos = framer_pkg::ATM_CAP_BYTES; // [R16]
        end
        n.nwords = framer_pkg::HDR_WORDS + 7'((n.pos + 10'h003) >> 2); // [R4]
      end
    end
    n.in_ready = n.en && n.st != framer_pkg::st_emit;
  end

  // --------------------------------------------------------------------
  // Registers and outputs
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.rtype <= framer_pkg::rec_type_t'(framer_pkg::CTRL_TYPE_RST);
      s.en <= framer_pkg::CTRL_EN_RST;
      s.snap <= framer_pkg::SNAP_RST;
      s.res <= framer_pkg::RES_RST;
    end else if (ce) begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.out_data;
  assign out_last = s.out_last;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [6:0] oidx;
  assign oidx = s.widx - 7'h01;

  sequence rec_start;
    ce && start;
  endsequence
  sequence word_at(int k);
    s.out_valid && oidx == 7'(k);
  endsequence

  a_stamp_capture: assert property (rec_start |=> s.tss == $past(ts_sec)) // [R18]
    else $error("seconds not latched at arrival");
  a_frac_resolution: assert property (word_at(0) |->
    (out_data & ~(32'hffff_ffff << s.res)) == 32'h0000_0000) // [R21]
    else $error("unresolved fraction bits not zero");
  a_rlen_order: assert property (word_at(2) |->
    {out_data[23:16], out_data[31:24]} == {7'h0, s.nwords, 2'b00}) // [R11]
    else $error("record length wrong or not big-endian");
  a_cell_length: assert property (word_at(2) && out_data[2:0] == 3'h3
    |-> {out_data[23:16], out_data[31:24]} == framer_pkg::ATM_REC_BYTES) // [R16]
    else $error("cell record length wrong");
  a_last_word: assert property (s.out_valid && s.out_last
    |-> oidx == s.nwords - 7'h01) // [R4]
    else $error("last flag on wrong word");
  a_eth_pad: assert property (word_at(4)
    && s.rtype == framer_pkg::ethernet_record_code
    |-> out_data[15:0] == 16'h0000) // [R17]
    else $error("ethernet pad bytes not zero");
  a_loss_saturate: assert property (ce && !ld3
    && s.lctr == framer_pkg::LOSS_MAX |=> s.lctr == framer_pkg::LOSS_MAX) // [R12]
    else $error("loss counter wrapped");
  a_loss_clear: assert property (ce && ld3 ##1 s.out_valid
    |-> s.lctr == {15'h0, $past(drop)}) // [R22]
    else $error("loss counter not cleared after report");
  a_trunc_flag: assert property (ce && s.st == framer_pkg::st_collect
    && in_valid && s.pos >= lim |=> s.trunc) // [R8]
    else $error("truncation not flagged");
  a_write_resp: assert property (ce && !s.awready && !s.wready
    && !s.bvalid |=> s.bvalid)
    else $error("write response missing");
  a_vary_flag: assert property (word_at(2) // [R7]
    |-> out_data[10] == (out_data[2:0] != 3'h3))
    else $error("varying length flag wrong");
  a_flag_reserved: assert property (word_at(2) // [R10]
    |-> out_data[15:14] == 2'b00)
    else $error("reserved flag bits not zero");
  a_ce_freeze: assert property (!ce |=> $stable(s))
    else $error("state moved while clock enable low");
endmodule // capture_record_framer

/* File: verification/record_sink.sv */
// Host memory model that stores the record words leaving the framer.
`timescale 1ns/10ps
module record_sink (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        out_last,
  output logic             out_ready
);
  logic [31:0] mem [0:127];
  logic [31:0] nwords;
  logic [31:0] rec_count;
  logic [31:0] idx;
  logic [1:0]  cyc;

  // Words are stored untouched; no header byte is interpreted.
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_ready <= 1'b0;
      cyc       <= 2'h0;
      idx       <= 32'h0000_0000;
      nwords    <= 32'h0000_0000;
      rec_count <= 32'h0000_0000;
    end else begin
      cyc       <= cyc + 2'h1;
      out_ready <= (cyc != 2'h3);
      if (out_valid && out_ready) begin
        mem[idx] <= out_data;
        if (out_last) begin
          nwords    <= idx + 32'h0000_0001;
          rec_count <= rec_count + 32'h0000_0001;
          idx       <= 32'h0000_0000;
        end else begin
          idx <= idx + 32'h0000_0001;
        end
      end
    end
  end
endmodule // record_sink

/* File: verification/tb.sv */
// Self-checking testbench of the capture record framer.
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, in_data = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, out_data, ts_sec, ts_frac;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, in_valid = 1'b0, in_first = 1'b0, in_last = 1'b0;
  logic in_err = 1'b0, fault = 1'b0, drop = 1'b0;
  logic [1:0] in_iface = 2'h0, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, in_ready;
  logic out_valid, out_last, out_ready;
  logic [2:0] rtype = 3'h1;
  logic [4:0] res = 5'h00;
  int snap = 256, err_count = 0, n_tests = 0, recs = 0;
  logic [31:0] rd;
  logic [1:0] rr;

  always #4 aclk = ~aclk;
  initial ts_sec = 32'h0000_0000;
  initial ts_frac = 32'h0000_0000;

  capture_record_framer u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ts_sec(ts_sec), .ts_frac(ts_frac),
    .in_valid(in_valid), .in_first(in_first), .in_last(in_last),
    .in_data(in_data), .in_err(in_err), .in_iface(in_iface),
    .in_ready(in_ready), .fault(fault), .drop(drop),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready));
  record_sink u_sink (.aclk(aclk), .aresetn(aresetn), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [7:0] byte_of(input int k);
    return 8'(k * 5 + 3);
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] sb, input logic [1:0] e);
    logic ad, wd;
    logic [1:0] br;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= sb; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 1'b0;
    check("bresp", 32'(br), 32'(e));
  endtask

  task automatic axi_read(input logic [7:0] a);
    logic ad;
    ad = 1'b0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ad && arready === 1'b1) begin ad = 1'b1; arvalid <= 1'b0; end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  task automatic set_ctrl(input logic [2:0] t);
    rtype = t;
    axi_write(framer_pkg::ADDR_CTRL, {23'h00_0000, 1'b1, 5'h00, t}, 4'hf,
              framer_pkg::RESP_OKAY);
  endtask

  task automatic set_snap(input int v);
    snap = v;
    axi_write(framer_pkg::ADDR_SNAP, 32'(v), 4'hf, framer_pkg::RESP_OKAY);
  endtask

  task automatic check_rec(input int n, input logic [1:0] ifc,
                           input logic er, fl, input logic [15:0] loss,
                           input logic [31:0] s, f);
    int pad, lim, st;
    logic [15:0] rl, wl;
    logic [7:0] fg, eb;
    pad = (rtype == 3'h2) ? 2 : 0;
    lim = (rtype == 3'h3) ? 52 : (rtype == 3'h2) ? snap + 2 : snap;
    if (lim > 256) lim = 256;
    st = (rtype == 3'h3 || n + pad >= lim) ? lim : n + pad;
    rl = 16'(16 + (st + 3) / 4 * 4);
    wl = 16'(n);
    fg = {2'b00, fl, er, n + pad > lim, rtype != 3'h3, ifc};
    check("words", u_sink.nwords, 32'(rl / 4));
    check("frac", u_sink.mem[0], f & (32'hffff_ffff << res));
    check("sec", u_sink.mem[1], s);
    check("hdr0", u_sink.mem[2], {rl[7:0], rl[15:8], fg, 5'h00, rtype});
    check("hdr1", u_sink.mem[3], {wl[7:0], wl[15:8], loss[7:0], loss[15:8]});
    for (int k = 0; k < rl - 16; k++) begin
      eb = (k < pad || k >= st || k >= n + pad) ? 8'h00 : byte_of(k - pad);
      check("body", 32'(u_sink.mem[4 + k / 4][8 * (k % 4) +: 8]), 32'(eb));
    end
  endtask

  task automatic run_frame(input int n, input logic [1:0] ifc,
                           input logic er, fl, input logic [15:0] loss);
    logic [31:0] s, f;
    s = 32'h4b00_0000 + 32'(recs);
    f = 32'hfedc_ba98 - 32'(recs * 77);
    ts_sec <= s; ts_frac <= f;
    for (int k = 0; k < n; k++) begin
      in_valid <= 1'b1; in_first <= (k == 0); in_last <= (k == n - 1);
      in_data <= byte_of(k); in_iface <= ifc; in_err <= er; fault <= fl;
      do @(posedge aclk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0; in_first <= 1'b0; in_last <= 1'b0;
    in_err <= 1'b0; fault <= 1'b0;
    recs++;
    while (u_sink.rec_count !== 32'(recs)) @(negedge aclk);
    check_rec(n, ifc, er, fl, loss, s, f);
    @(posedge aclk);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    axi_read(framer_pkg::ADDR_CTRL);
    check("ctrl", rd, 32'h0000_0101);
    axi_read(framer_pkg::ADDR_SNAP);
    check("snap", rd, 32'(framer_pkg::SNAP_RST));
    axi_read(8'h40);
    check("unmapped", 32'(rr), 32'(framer_pkg::RESP_DECERR));
    check("unmapped data", rd, 32'h0000_0000);
    axi_write(8'h40, 32'h0000_0000, 4'hf, framer_pkg::RESP_DECERR);
    axi_write(framer_pkg::ADDR_SNAP, 32'h0000_00ab, 4'h1,
              framer_pkg::RESP_OKAY);
    axi_read(framer_pkg::ADDR_SNAP);
    check("snap strobe", rd, 32'h0000_01ab);
    set_snap(256);
  endtask

  task automatic t_hdlc;
    axi_write(framer_pkg::ADDR_RES, 32'h0000_0008, 4'hf,
              framer_pkg::RESP_OKAY);
    res = 5'h08;
    for (int i = 0; i < 3; i++) begin
      drop <= 1'b1; @(posedge aclk); drop <= 1'b0; @(posedge aclk);
    end
    ce <= 1'b0;
    drop <= 1'b1;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    drop <= 1'b0;
    @(posedge aclk);
    run_frame(6, 2'h2, 1'b1, 1'b0, 16'h0003);
    run_frame(5, 2'h1, 1'b0, 1'b0, 16'h0000);
  endtask

  task automatic t_types;
    for (int t = 0; t < 8; t++) begin
      set_ctrl(3'(t));
      run_frame(3, 2'(t), 1'b0, 1'b0, 16'h0000);
    end
  endtask

  task automatic t_layouts;
    set_ctrl(3'h3);
    run_frame(60, 2'h3, 1'b0, 1'b1, 16'h0000);
    set_ctrl(3'h2);
    run_frame(9, 2'h0, 1'b0, 1'b1, 16'h0000);
    set_ctrl(3'h1);
    set_snap(4);
    run_frame(10, 2'h1, 1'b0, 1'b0, 16'h0000);
    set_snap(511);
    run_frame(300, 2'h2, 1'b1, 1'b0, 16'h0000);
    set_snap(256);
  endtask

  task automatic t_loss_sat;
    drop <= 1'b1;
    repeat (66000) @(posedge aclk);
    drop <= 1'b0;
    @(posedge aclk);
    axi_read(framer_pkg::ADDR_STAT);
    check("loss", {16'h0000, rd[15:0]}, 32'h0000_ffff);
    run_frame(2, 2'h0, 1'b0, 1'b0, 16'hffff);
    run_frame(2, 2'h0, 1'b0, 1'b0, 16'h0000);
    axi_read(framer_pkg::ADDR_COUNT);
    check("count", rd, 32'(recs));
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_hdlc();
    t_types();
    t_layouts();
    t_loss_sat();
    finish_test();
  end

  initial begin
    repeat (95000) @(posedge aclk);
    err_count++;
    finish_test();
  end
endmodule // tb
